// ---- hw/tsp_pkg.sv ----
package tsp_pkg;

  localparam int NUM_TERMS = 5;
  localparam int SEL_W     = 8;

  // Option codes placed on the per-terminal input function selectors
  localparam logic [7:0] OPT_OUTSIDE_FAULT = 8'h0C;
  localparam logic [7:0] OPT_POWERUP_GUARD = 8'h0D;

  // Fault codes shown on the display
  localparam logic [7:0] CODE_NONE               = 8'h00;
  localparam logic [7:0] UNDERVOLTAGE_FAULT_CODE = 8'h09;
  localparam logic [7:0] OUTSIDE_FAULT_CODE      = 8'h0C;
  localparam logic [7:0] GUARD_FAULT_CODE        = 8'h0D;

  // Trip history bit positions
  localparam int HIST_W     = 3;
  localparam int HIST_EXT   = 0;
  localparam int HIST_GUARD = 1;
  localparam int HIST_UV    = 2;

  // Timing
  localparam int CLK_HZ        = 125_000_000;
  localparam int RS_MIN_MS     = 12;
  localparam int ALARM_CLR_MS  = 30;
  localparam int RS_MIN_CYC    = RS_MIN_MS * (CLK_HZ / 1000);
  localparam int ALARM_MAX_CYC = ALARM_CLR_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 22;

  // Cycles for the input synchronisers to fill after reset
  localparam logic [1:0] SETTLE_CNT = 2'h3;

  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_RUN,
    MODE_TRIP,
    MODE_RESET
  } tsp_mode_t;

  function automatic logic tsp_has_func(input logic [SEL_W-1:0] sel,
                                        input logic [SEL_W-1:0] code);
    tsp_has_func = (sel == code);
  endfunction

endpackage

// ---- hw/tsp_cond_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface tsp_cond_if;
  logic fault_edge;
  logic guard_on;
  logic run_lvl;
  logic rs_lvl;
  logic kp_lvl;
  logic uv_lvl;
  logic settled;

  modport src  (output fault_edge, guard_on, run_lvl, rs_lvl, kp_lvl,
                uv_lvl, settled);
  modport sink (input  fault_edge, guard_on, run_lvl, rs_lvl, kp_lvl,
                uv_lvl, settled);
endinterface

`default_nettype wire

// ---- hw/tsp_input_cond.sv ----
`timescale 1ns/1ps
`default_nettype none

module tsp_input_cond (
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic [tsp_pkg::NUM_TERMS-1:0]       term_i,
  input  wire logic [tsp_pkg::NUM_TERMS-1:0][7:0]  sel_i,
  input  wire logic                                run_i,
  input  wire logic                                rs_i,
  input  wire logic                                kp_i,
  input  wire logic                                uv_i,
  tsp_cond_if.src                                  cond
);

  localparam int NSYNC = tsp_pkg::NUM_TERMS + 4;

  logic [NSYNC-1:0]                  meta_q;
  logic [NSYNC-1:0]                  sync_q;
  logic [tsp_pkg::NUM_TERMS-1:0]     fault_hit;
  logic [tsp_pkg::NUM_TERMS-1:0]     guard_hit;
  logic                              fault_lvl;
  logic                              fault_prev_q;
  logic [1:0]                        settle_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only sync_q is read by logic
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {uv_i, kp_i, rs_i, run_i, term_i};
      sync_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function decode, only the five programmable terminals take part
  genvar g;
  generate
    for (g = 0; g < tsp_pkg::NUM_TERMS; g++) begin : g_term
      assign fault_hit[g] = sync_q[g] &
          tsp_pkg::tsp_has_func(sel_i[g], tsp_pkg::OPT_OUTSIDE_FAULT);
      assign guard_hit[g] = sync_q[g] &
          tsp_pkg::tsp_has_func(sel_i[g], tsp_pkg::OPT_POWERUP_GUARD);
    end
  endgenerate

  assign fault_lvl = |fault_hit;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fault_prev_q <= 1'b0;
      settle_q     <= 2'h0;
    end else begin
      fault_prev_q <= fault_lvl;
      if (settle_q != tsp_pkg::SETTLE_CNT)
        settle_q <= settle_q + 2'h1;
    end
  end

  // Only OFF-to-ON counts; ON-to-OFF raises nothing
  assign cond.fault_edge = fault_lvl & ~fault_prev_q;
  assign cond.guard_on   = |guard_hit;
  assign cond.run_lvl    = sync_q[tsp_pkg::NUM_TERMS];
  assign cond.rs_lvl     = sync_q[tsp_pkg::NUM_TERMS+1];
  assign cond.kp_lvl     = sync_q[tsp_pkg::NUM_TERMS+2];
  assign cond.uv_lvl     = sync_q[tsp_pkg::NUM_TERMS+3];
  assign cond.settled    = (settle_q == tsp_pkg::SETTLE_CNT);

endmodule

`default_nettype wire

// ---- hw/tsp_trip_guard.sv ----
// Function
// - Outside fault rising edge latches trip, stops output
// - Trip stays after fault input drops
// - Only reset or power cycle clears; then stop
// - On trip output off, alarm at once
// - Reset clears alarm; release resumes if running
// - Falling fault edge no trip; history kept
// - Guard: no self restart after undervoltage clear
// - No guard: start at power-up if run
// - Guard and run at power-up: guard trip
// - Guard alarm cleared by run off or reset
// - Fresh run after guard clear starts output
// - Guard error reset with run: resume
// - Undervoltage cleared by reset: guard check again
// - Guard off: resume run held at power-up
// - Functions only on five programmable terminals
// - Alarm drops within 30 ms of reset
`timescale 1ns/1ps
`default_nettype none

module tsp_trip_guard #(
  parameter int RS_MIN_CYC    = tsp_pkg::RS_MIN_CYC,
  parameter int ALARM_MAX_CYC = tsp_pkg::ALARM_MAX_CYC
) (
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic [tsp_pkg::NUM_TERMS-1:0]       input_terminals_i,
  input  wire logic [tsp_pkg::NUM_TERMS-1:0][7:0]  input_function_selectors_i,
  input  wire logic                                run_cmd_i,
  input  wire logic                                reset_terminal_input_i,
  input  wire logic                                keypad_reset_i,
  input  wire logic                                undervoltage_i,
  output var  logic                                drive_en_o,
  output var  logic                                alarm_o,
  output var  logic [7:0]                          fault_code_o,
  output var  logic [tsp_pkg::HIST_W-1:0]          trip_history_o
);

  localparam logic [tsp_pkg::CNT_W-1:0] RS_ACC =
      tsp_pkg::CNT_W'(RS_MIN_CYC - 1);
  localparam logic [tsp_pkg::CNT_W-1:0] RS_SAT =
      tsp_pkg::CNT_W'(RS_MIN_CYC);

  tsp_cond_if cond ();

  tsp_input_cond u_cond (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .term_i    (input_terminals_i),
    .sel_i     (input_function_selectors_i),
    .run_i     (run_cmd_i),
    .rs_i      (reset_terminal_input_i),
    .kp_i      (keypad_reset_i),
    .uv_i      (undervoltage_i),
    .cond      (cond)
  );

  tsp_pkg::tsp_mode_t            mode_q, mode_d;
  logic [7:0]                    code_q, code_d;
  logic [tsp_pkg::HIST_W-1:0]    hist_q, hist_d;
  logic                          check_q, check_d;
  logic [tsp_pkg::CNT_W-1:0]     rs_cnt_q;
  logic                          kp_prev_q;
  logic                          drive_q;
  logic                          alarm_q;

  wire rs_accept   = cond.rs_lvl && (rs_cnt_q == RS_ACC);
  wire kp_pulse    = cond.kp_lvl && !kp_prev_q;
  wire ext_trip    = cond.settled && cond.fault_edge;
  wire uv_trip     = cond.settled && cond.uv_lvl;
  wire guard_block = cond.guard_on && cond.run_lvl;
  wire was_uv      = (code_q == tsp_pkg::UNDERVOLTAGE_FAULT_CODE);
  wire [7:0] new_code = ext_trip ? tsp_pkg::OUTSIDE_FAULT_CODE
                                 : tsp_pkg::UNDERVOLTAGE_FAULT_CODE;
  wire [tsp_pkg::HIST_W-1:0] new_hist = ext_trip
      ? tsp_pkg::HIST_W'(1 << tsp_pkg::HIST_EXT)
      : tsp_pkg::HIST_W'(1 << tsp_pkg::HIST_UV);

  ////////////////////////////////////////////////////////////////////////////
  // Reset terminal qualifier: pulses shorter than the minimum are ignored
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i)
      rs_cnt_q <= '0;
    else if (!cond.rs_lvl)
      rs_cnt_q <= '0;
    else if (rs_cnt_q != RS_SAT)
      rs_cnt_q <= rs_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing; reset beats keypad, keypad beats new trips
  always_comb begin
    mode_d  = mode_q;
    code_d  = code_q;
    hist_d  = hist_q;
    check_d = check_q;
    if (rs_accept) begin
      // Output held off while the terminal stays ON
      mode_d  = tsp_pkg::MODE_RESET;
      code_d  = tsp_pkg::CODE_NONE;
      hist_d  = '0;
      check_d = check_q | was_uv;
    end else if (mode_q == tsp_pkg::MODE_RESET) begin
      if (!cond.rs_lvl)
        mode_d = tsp_pkg::MODE_STOP;
    end else if (kp_pulse) begin
      mode_d  = tsp_pkg::MODE_STOP;
      code_d  = tsp_pkg::CODE_NONE;
      hist_d  = '0;
      check_d = check_q | was_uv;
    end else if (mode_q == tsp_pkg::MODE_TRIP) begin
      // Later fault edges cannot overwrite the shown code
      if (code_q == tsp_pkg::GUARD_FAULT_CODE && !cond.run_lvl) begin
        mode_d = tsp_pkg::MODE_STOP;
        code_d = tsp_pkg::CODE_NONE;
      end
    end else if (ext_trip || uv_trip) begin
      mode_d = tsp_pkg::MODE_TRIP;
      code_d = new_code;
      hist_d = hist_q | new_hist;
    end else if (cond.settled && check_q) begin
      check_d = 1'b0;
      if (guard_block) begin
        mode_d = tsp_pkg::MODE_TRIP;
        code_d = tsp_pkg::GUARD_FAULT_CODE;
        hist_d = hist_q | tsp_pkg::HIST_W'(1 << tsp_pkg::HIST_GUARD);
      end
    end else if (cond.settled) begin
      // Level-started run: covers power-up and release after reset
      if (mode_q == tsp_pkg::MODE_STOP && cond.run_lvl)
        mode_d = tsp_pkg::MODE_RUN;
      else if (mode_q == tsp_pkg::MODE_RUN && !cond.run_lvl)
        mode_d = tsp_pkg::MODE_STOP;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_q    <= tsp_pkg::MODE_STOP;
      code_q    <= tsp_pkg::CODE_NONE;
      hist_q    <= '0;
      check_q   <= 1'b1;
      kp_prev_q <= 1'b0;
      drive_q   <= 1'b0;
      alarm_q   <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      code_q    <= code_d;
      hist_q    <= hist_d;
      check_q   <= check_d;
      kp_prev_q <= cond.kp_lvl;
      drive_q   <= (mode_d == tsp_pkg::MODE_RUN);
      alarm_q   <= (mode_d == tsp_pkg::MODE_TRIP);
    end
  end

  assign drive_en_o     = drive_q;
  assign alarm_o        = alarm_q;
  assign fault_code_o   = code_q;
  assign trip_history_o = hist_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  wire quiet = !rs_accept && !kp_pulse && mode_q != tsp_pkg::MODE_RESET;

  a_ext_trip_latch: assert property (
    ext_trip && quiet && mode_q != tsp_pkg::MODE_TRIP |=>
      alarm_o && !drive_en_o && fault_code_o == tsp_pkg::OUTSIDE_FAULT_CODE)
    else $error("outside fault edge did not trip");

  a_trip_holds: assert property (
    mode_q == tsp_pkg::MODE_TRIP &&
    code_q == tsp_pkg::OUTSIDE_FAULT_CODE && quiet |=>
      mode_q == tsp_pkg::MODE_TRIP)
    else $error("outside fault trip left without reset");

  a_trip_output_off: assert property (
    mode_q == tsp_pkg::MODE_TRIP |-> alarm_o && !drive_en_o)
    else $error("trip without alarm or with drive");

  a_reset_clear: assert property (
    rs_accept |=> !alarm_o && !drive_en_o &&
      fault_code_o == tsp_pkg::CODE_NONE && trip_history_o == '0)
    else $error("reset did not clear alarm");

  a_alarm_deadline: assert property (
    cond.rs_lvl && rs_cnt_q == RS_SAT |-> !alarm_o)
    else $error("alarm still on after reset window");

  // Reset acceptance must fit inside the alarm clear budget
  a_alarm_budget: assert property (
    RS_MIN_CYC < ALARM_MAX_CYC)
    else $error("reset qualifier longer than alarm budget");

  a_guard_powerup: assert property (
    cond.settled && check_q && quiet && !ext_trip && !uv_trip &&
    mode_q != tsp_pkg::MODE_TRIP && guard_block |=>
      fault_code_o == tsp_pkg::GUARD_FAULT_CODE ##1 !drive_en_o)
    else $error("guard did not block start");

  a_noguard_start: assert property (
    cond.settled && check_q && quiet && !ext_trip && !uv_trip &&
    mode_q == tsp_pkg::MODE_STOP && !cond.guard_on && cond.run_lvl &&
    !$past(cond.settled) ##1 quiet && !ext_trip && !uv_trip |=>
      drive_en_o)
    else $error("no start at power-up without guard");

  a_guard_run_off: assert property (
    mode_q == tsp_pkg::MODE_TRIP && !cond.run_lvl && quiet &&
    code_q == tsp_pkg::GUARD_FAULT_CODE |=> !alarm_o)
    else $error("guard alarm not cleared by run off");

  a_first_code: assert property (
    mode_q == tsp_pkg::MODE_TRIP && quiet && cond.run_lvl |=>
      $stable(fault_code_o))
    else $error("latched fault code replaced");

  c_ext_trip:   cover property (ext_trip && mode_q == tsp_pkg::MODE_RUN);
  c_guard_trip: cover property (code_d == tsp_pkg::GUARD_FAULT_CODE &&
                                code_q == tsp_pkg::CODE_NONE);
  c_reset_run:  cover property (mode_q == tsp_pkg::MODE_RESET ##[1:8]
                                drive_en_o);
  c_uv_recheck: cover property (rs_accept && was_uv);

endmodule

`default_nettype wire

// ---- verification/tsp_ext_equip.sv ----
`timescale 1ns/1ps
`default_nettype none

module tsp_ext_equip #(
  parameter int RS_HOLD  = 24,
  parameter int RUN_WAIT = 30
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] term_i,
  input  wire logic       run_i,
  input  wire logic       early_i,
  input  wire logic       kp_i,
  input  wire logic       uv_i,
  input  wire logic       rs_req_i,
  output var  logic [4:0] term_o,
  output var  logic       run_o,
  output var  logic       kp_o,
  output var  logic       uv_o,
  output var  logic       rs_o
);
  // Counters start known; outputs other than rs_o get their only driver at the first edge
  int rs_cnt = 0;
  int wait_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Levels change on the falling edge, away from the sampling edge
  always @(negedge ref_clk_i) begin
    term_o <= term_i;
    kp_o <= kp_i;
    uv_o <= uv_i;
    // Run held back after power-up unless a scenario wants an early run
    run_o <= run_i && (early_i || wait_cnt >= RUN_WAIT);
    if (!rst_n_i) begin
      wait_cnt <= 0;
    end else if (wait_cnt < RUN_WAIT) begin
      wait_cnt <= wait_cnt + 1;
    end
    // Pulse always outlasts the minimum accepted width
    if (rs_cnt != 0) begin
      rs_cnt <= rs_cnt - 1;
    end else if (rs_req_i) begin
      rs_cnt <= RS_HOLD;
    end
  end

  assign rs_o = (rs_cnt != 0);
endmodule

`default_nettype wire

// ---- verification/tsp_trip_guard_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tsp_trip_guard_tb_top;
  localparam int RS_MIN  = 12;
  localparam int RS_HOLD = 24;
  localparam logic [2:0] H_EXT = 3'(1 << tsp_pkg::HIST_EXT);
  localparam logic [2:0] H_GRD = 3'(1 << tsp_pkg::HIST_GUARD);
  localparam logic [2:0] H_UV  = 3'(1 << tsp_pkg::HIST_UV);
  localparam logic [7:0] C_NO  = tsp_pkg::CODE_NONE;

  logic                               clk;
  logic                               rst_n;
  logic [tsp_pkg::NUM_TERMS-1:0][7:0] sel;
  logic [4:0]                         term;
  logic [4:0]                         term_w;
  logic                               run;
  logic                               early;
  logic                               kp;
  logic                               uv;
  logic                               rs_req;
  logic                               run_w;
  logic                               kp_w;
  logic                               uv_w;
  logic                               rs_w;
  logic                               drive_en;
  logic                               alarm;
  logic [7:0]                         code;
  logic [2:0]                         hist;
  int                                 n_errors;
  int                                 cmp_count;
  int                                 cyc = 0;

  tsp_ext_equip #(.RS_HOLD(RS_HOLD), .RUN_WAIT(30)) partner_u (
    .ref_clk_i(clk), .rst_n_i(rst_n), .term_i(term), .run_i(run),
    .early_i(early), .kp_i(kp), .uv_i(uv), .rs_req_i(rs_req),
    .term_o(term_w), .run_o(run_w), .kp_o(kp_w), .uv_o(uv_w), .rs_o(rs_w)
  );

  tsp_trip_guard #(.RS_MIN_CYC(RS_MIN), .ALARM_MAX_CYC(40)) dut_u (
    .ref_clk_i(clk), .rst_n_i(rst_n), .input_terminals_i(term_w),
    .input_function_selectors_i(sel), .run_cmd_i(run_w),
    .reset_terminal_input_i(rs_w), .keypad_reset_i(kp_w),
    .undervoltage_i(uv_w), .drive_en_o(drive_en), .alarm_o(alarm),
    .fault_code_o(code), .trip_history_o(hist)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_out(input logic d, input logic a, input logic [7:0] c,
                         input logic [2:0] h);
    chk("drive_en", {7'h00, drive_en}, {7'h00, d});
    chk("alarm", {7'h00, alarm}, {7'h00, a});
    chk("fault_code", code, c);
    chk("history", {5'h00, hist}, {5'h00, h});
  endtask

  task automatic power_up(input logic g, input logic r, input logic e);
    rst_n <= 1'h0;
    term <= {3'h0, g, 1'h0};
    run <= r;
    early <= e;
    tick(5);
    rst_n <= 1'h1;
    tick(12);
  endtask

  // Alarm must already be down while the pulse is still held
  task automatic rs_pulse();
    rs_req <= 1'h1;
    tick(1);
    rs_req <= 1'h0;
    tick(RS_HOLD - 2);
    chk("alarm in reset", {7'h00, alarm}, 8'h00);
    tick(10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_guard_run();
    power_up(1'h1, 1'h1, 1'h1);
    chk_out(1'h0, 1'h1, tsp_pkg::GUARD_FAULT_CODE, H_GRD);
    run <= 1'h0;
    tick(6);
    chk_out(1'h0, 1'h0, C_NO, H_GRD);
    run <= 1'h1;
    tick(6);
    chk_out(1'h1, 1'h0, C_NO, H_GRD);
  endtask

  task automatic s_ext_trip();
    term <= 5'h03;
    tick(6);
    chk_out(1'h0, 1'h1, tsp_pkg::OUTSIDE_FAULT_CODE, H_GRD | H_EXT);
    term <= 5'h02;
    tick(6);
    chk_out(1'h0, 1'h1, tsp_pkg::OUTSIDE_FAULT_CODE, H_GRD | H_EXT);
    uv <= 1'h1;
    term <= 5'h03;
    tick(6);
    chk("kept code", code, tsp_pkg::OUTSIDE_FAULT_CODE);
    uv <= 1'h0;
    rs_pulse();
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
    term <= 5'h02;
    tick(6);
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
  endtask

  task automatic s_plain_start();
    power_up(1'h0, 1'h1, 1'h1);
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
    term <= 5'h08;
    tick(6);
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
    power_up(1'h1, 1'h1, 1'h0);
    chk_out(1'h0, 1'h0, C_NO, 3'h0);
    tick(30);
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
  endtask

  task automatic s_guard_clear();
    power_up(1'h1, 1'h1, 1'h1);
    rs_pulse();
    chk_out(1'h1, 1'h0, C_NO, 3'h0);
    power_up(1'h1, 1'h1, 1'h1);
    kp <= 1'h1;
    tick(2);
    kp <= 1'h0;
    tick(6);
    chk("kp alarm", {7'h00, alarm}, 8'h00);
    chk("kp code", code, C_NO);
  endtask

  // Undervoltage cleared by reset while run is held still meets the guard
  task automatic s_uv_guard();
    power_up(1'h1, 1'h1, 1'h0);
    tick(30);
    uv <= 1'h1;
    tick(6);
    chk_out(1'h0, 1'h1, tsp_pkg::UNDERVOLTAGE_FAULT_CODE, H_UV);
    uv <= 1'h0;
    rs_pulse();
    chk_out(1'h0, 1'h1, tsp_pkg::GUARD_FAULT_CODE, H_GRD);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_n = 1'h0;
    sel = '{8'h00, 8'h00, 8'h00, tsp_pkg::OPT_POWERUP_GUARD,
            tsp_pkg::OPT_OUTSIDE_FAULT};
    term = 5'h00;
    run = 1'h0;
    early = 1'h0;
    kp = 1'h0;
    uv = 1'h0;
    rs_req = 1'h0;
    s_guard_run();
    s_ext_trip();
    s_plain_start();
    s_guard_clear();
    s_uv_guard();
    wrap_up();
  end
endmodule

`default_nettype wire
